//--- common/oled_host_pkg.sv
// Package with register map, pin types and timing of the OLED host port.
package oled_host_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned T_CYCLE_NS = 300;
  localparam int unsigned T_CSL_NS = 120;
  localparam int unsigned T_CSH_NS = 60;
  localparam int unsigned T_DHW_NS = 15;
  localparam int unsigned T_ACC_NS = 140;
  localparam int unsigned SYNC_CYC = 3;
  localparam int unsigned SETUP_CYC = 1;

  function automatic int unsigned ns_up(input int unsigned ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction : ns_up

  function automatic int unsigned max2(input int unsigned a,
                                       input int unsigned b);
    return (a > b) ? a : b;
  endfunction : max2

  // The low phase also covers access time plus the input synchroniser.
  localparam int unsigned STB_CYC =
    max2(ns_up(T_CSL_NS), ns_up(T_ACC_NS) + SYNC_CYC + 2);
  localparam int unsigned HOLD_CYC = ns_up(T_DHW_NS);
  localparam int unsigned GAP_CYC = max2(ns_up(T_CSH_NS),
    ns_up(T_CYCLE_NS) - SETUP_CYC - STB_CYC - HOLD_CYC);
  localparam int unsigned CNT_W = 8;
  localparam int unsigned RST_CNT_W = 24;

  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_TXD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] REG_RXD = 4'hC;
  localparam int unsigned CTRL_INIT_BIT = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;
  localparam int unsigned TXD_DC_BIT = 8;
  localparam int unsigned TXD_RD_BIT = 9;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_RXV_BIT = 2;
  localparam int unsigned STAT_ERR_BIT = 3;

  localparam int unsigned INIT_LEN = 18;
  localparam int unsigned IDX_W = 5;
  localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0] CMD_DISP_ON = 8'hAF;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic dc;
    logic init_n;
  } ctl_pins_s;

  typedef struct packed {
    logic [7:0] data;
    logic oe;
  } bus_drive_s;

  typedef struct packed {
    logic rd;
    logic dc;
    logic [7:0] data;
  } xfer_req_s;

  typedef enum logic [2:0] {X_IDLE, X_SETUP, X_STROBE, X_HOLD, X_GAP}
    xfer_st_e;
  typedef enum logic [1:0] {I_HOLD, I_WAIT, I_SEQ, I_DONE} init_st_e;
endpackage : oled_host_pkg

//--- core/oled_host_port.sv
// Host controller that powers up and drives a strobed OLED parallel port.
`timescale 1ns/1ps
// How it works
// - Eight-bit bus, host drives writes only.
// - Command write: select, strobe, release, deselect.
// - Hold init low, release, display off.
// - Contrast command then maximum current.
// - Duty command then sixty-three.
// - Start line zero, row scan direction.
// - Row pin arrangement command and parameter.
// - Precharge command, fifteen and one.
// - Row high deselect level command, parameter.
// - Normal display, non-inverted pixels.
// - Display on ends the sequence.
module oled_host_port #(
  parameter int unsigned RST_LOW_CYC = 12500,
  parameter int unsigned RST_WAIT_CYC = 12500
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [oled_host_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output oled_host_pkg::ctl_pins_s pins_o,
  output oled_host_pkg::bus_drive_s bus_o,
  input wire logic [7:0] host_bus_byte_i
);
  import oled_host_pkg::*;

  if (RST_LOW_CYC < 1 || RST_LOW_CYC >= (1 << RST_CNT_W) ||
      RST_WAIT_CYC < 1 || RST_WAIT_CYC >= (1 << RST_CNT_W) ||
      GAP_CYC >= (1 << CNT_W) || STB_CYC >= (1 << CNT_W)) begin : g_chk
    $error("oled_host_port: count parameter out of range");
  end

  function automatic logic [7:0] init_byte(input logic [IDX_W-1:0] i);
    case (i)
      5'd0: init_byte = CMD_DISP_OFF;
      5'd1: init_byte = 8'h81;
      5'd2: init_byte = 8'hFF;
      5'd3: init_byte = 8'hA8;
      5'd4: init_byte = 8'h3F;
      5'd5: init_byte = 8'hA0;
      5'd6: init_byte = 8'hD3;
      5'd7: init_byte = 8'h00;
      5'd8: init_byte = 8'h40;
      5'd9: init_byte = 8'hC8;
      5'd10: init_byte = 8'hDA;
      5'd11: init_byte = 8'h12;
      5'd12: init_byte = 8'hD9;
      5'd13: init_byte = 8'hF1;
      5'd14: init_byte = 8'hDB;
      5'd15: init_byte = 8'h49;
      5'd16: init_byte = 8'hA4;
      5'd17: init_byte = 8'hA6;
      default: init_byte = CMD_DISP_ON;
    endcase
  endfunction : init_byte

  xfer_st_e x_st_ff;
  init_st_e i_st_ff;
  xfer_req_s cur_ff;
  xfer_req_s sw_req_ff;
  logic sw_pend_ff;
  logic [CNT_W-1:0] x_cnt_ff;
  logic [RST_CNT_W-1:0] i_cnt_ff;
  logic [IDX_W-1:0] idx_ff;
  logic [7:0] bus_s1_ff;
  logic [7:0] bus_s2_ff;
  logic [7:0] bus_s3_ff;
  logic [7:0] bus_filt_ff;
  logic [7:0] rx_ff;
  logic rx_valid_ff;
  logic err_ff;
  logic x_idle;
  logic seq_go;
  logic sw_go;
  logic tx_wr;
  logic rx_set;
  logic init_start;
  logic busy;

  assign x_idle = (x_st_ff == X_IDLE);
  // The nineteen-byte sequence issues the final display-on byte at INIT_LEN.
  assign seq_go = (i_st_ff == I_SEQ) && x_idle && (idx_ff <= IDX_W'(INIT_LEN));
  assign sw_go = (i_st_ff == I_DONE) && x_idle && sw_pend_ff;
  assign tx_wr = reg_wr_i && (reg_addr_i == REG_TXD);
  assign init_start = reg_wr_i && (reg_addr_i == REG_CTRL) &&
                      reg_wdata_i[CTRL_INIT_BIT];
  assign rx_set = (x_st_ff == X_STROBE) && (x_cnt_ff == '0) && cur_ff.rd;
  assign busy = sw_pend_ff || !x_idle || (i_st_ff != I_DONE);

  // Power-up: hold the init line low, let the device settle, then send.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || init_start) begin
      i_st_ff <= I_HOLD;
      i_cnt_ff <= '0;
      idx_ff <= '0;
    end else begin
      case (i_st_ff)
        I_HOLD: begin
          if (i_cnt_ff == RST_CNT_W'(RST_LOW_CYC - 1)) begin
            i_st_ff <= I_WAIT;
            i_cnt_ff <= '0;
          end else begin
            i_cnt_ff <= i_cnt_ff + 1'b1;
          end
        end
        I_WAIT: begin
          if (i_cnt_ff == RST_CNT_W'(RST_WAIT_CYC - 1)) begin
            i_st_ff <= I_SEQ;
          end else begin
            i_cnt_ff <= i_cnt_ff + 1'b1;
          end
        end
        I_SEQ: begin
          if (seq_go) begin
            idx_ff <= idx_ff + 1'b1;
          end else if (x_idle) begin
            i_st_ff <= I_DONE;
          end
        end
        I_DONE: i_st_ff <= I_DONE;
        default: i_st_ff <= I_HOLD;
      endcase
    end
  end

  // One software request may wait; a second while it waits is refused.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sw_pend_ff <= 1'b0;
      sw_req_ff <= '0;
    end else if (tx_wr && !sw_pend_ff && i_st_ff == I_DONE) begin
      sw_pend_ff <= 1'b1;
      sw_req_ff <= {reg_wdata_i[TXD_RD_BIT], reg_wdata_i[TXD_DC_BIT],
                    reg_wdata_i[7:0]};
    end else if (sw_go) begin
      sw_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      err_ff <= 1'b0;
    end else if (tx_wr && (sw_pend_ff || i_st_ff != I_DONE)) begin
      err_ff <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == REG_CTRL &&
                 reg_wdata_i[CTRL_CLR_BIT]) begin
      err_ff <= 1'b0;
    end
  end

  // Transfer engine: setup, strobe low, hold, then deselected gap.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      x_st_ff <= X_IDLE;
      x_cnt_ff <= '0;
      cur_ff <= '0;
    end else begin
      case (x_st_ff)
        X_IDLE: begin
          if (seq_go) begin
            cur_ff <= {1'b0, 1'b0, init_byte(idx_ff)};
            x_st_ff <= X_SETUP;
            x_cnt_ff <= CNT_W'(SETUP_CYC - 1);
          end else if (sw_go) begin
            cur_ff <= sw_req_ff;
            x_st_ff <= X_SETUP;
            x_cnt_ff <= CNT_W'(SETUP_CYC - 1);
          end
        end
        X_SETUP: begin
          if (x_cnt_ff == '0) begin
            x_st_ff <= X_STROBE;
            x_cnt_ff <= CNT_W'(STB_CYC - 1);
          end else begin
            x_cnt_ff <= x_cnt_ff - 1'b1;
          end
        end
        X_STROBE: begin
          if (x_cnt_ff == '0) begin
            x_st_ff <= X_HOLD;
            x_cnt_ff <= CNT_W'(HOLD_CYC - 1);
          end else begin
            x_cnt_ff <= x_cnt_ff - 1'b1;
          end
        end
        X_HOLD: begin
          if (x_cnt_ff == '0) begin
            x_st_ff <= X_GAP;
            x_cnt_ff <= CNT_W'(GAP_CYC - 1);
          end else begin
            x_cnt_ff <= x_cnt_ff - 1'b1;
          end
        end
        X_GAP: begin
          if (x_cnt_ff == '0) begin
            x_st_ff <= X_IDLE;
          end else begin
            x_cnt_ff <= x_cnt_ff - 1'b1;
          end
        end
        default: x_st_ff <= X_IDLE;
      endcase
    end
  end

  // Pins follow the engine one cycle late, so every phase keeps its length.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pins_o <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, dc: 1'b1,
                  init_n: 1'b0};
      bus_o <= '0;
    end else begin
      pins_o.cs_n <= !(x_st_ff inside {X_SETUP, X_STROBE, X_HOLD});
      pins_o.wr_n <= !(x_st_ff == X_STROBE && !cur_ff.rd);
      pins_o.rd_n <= !(x_st_ff == X_STROBE && cur_ff.rd);
      pins_o.dc <= x_idle ? 1'b1 : cur_ff.dc;
      pins_o.init_n <= (i_st_ff != I_HOLD);
      bus_o.oe <= !cur_ff.rd &&
                  (x_st_ff inside {X_SETUP, X_STROBE, X_HOLD});
      bus_o.data <= cur_ff.data;
    end
  end

  // The bus input is asynchronous; only agreed samples count.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bus_s1_ff <= '0;
      bus_s2_ff <= '0;
      bus_s3_ff <= '0;
      bus_filt_ff <= '0;
    end else begin
      bus_s1_ff <= host_bus_byte_i;
      bus_s2_ff <= bus_s1_ff;
      bus_s3_ff <= bus_s2_ff;
      if (bus_s2_ff == bus_s3_ff) begin
        bus_filt_ff <= bus_s3_ff;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rx_ff <= '0;
      rx_valid_ff <= 1'b0;
    end else if (rx_set) begin
      rx_ff <= bus_filt_ff;
      rx_valid_ff <= 1'b1;
    end else if (reg_rd_i && reg_addr_i == REG_RXD) begin
      rx_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= '0;
      case (reg_addr_i)
        REG_STAT: begin
          reg_rdata_o[STAT_BUSY_BIT] <= busy;
          reg_rdata_o[STAT_DONE_BIT] <= (i_st_ff == I_DONE);
          reg_rdata_o[STAT_RXV_BIT] <= rx_valid_ff;
          reg_rdata_o[STAT_ERR_BIT] <= err_ff;
        end
        REG_RXD: reg_rdata_o[7:0] <= rx_ff;
        default: reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // Helper state read only by the checks below.
  logic [RST_CNT_W-1:0] low_cnt_ff;
  logic first_wr_ff;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      low_cnt_ff <= '0;
      first_wr_ff <= 1'b0;
    end else begin
      low_cnt_ff <= pins_o.init_n ? '0 : low_cnt_ff + 1'b1;
      if (!pins_o.init_n) begin
        first_wr_ff <= 1'b1;
      end else if (!pins_o.wr_n) begin
        first_wr_ff <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence cs_gap_s;
    pins_o.cs_n [*8];
  endsequence
  sequence wr_low_s;
    !pins_o.wr_n [*7];
  endsequence

  chk_strobe_excl: assert property (pins_o.wr_n || pins_o.rd_n)
    else $error("read and write strobes low together");
  chk_strobe_cs: assert property (
    (!pins_o.wr_n || !pins_o.rd_n) |-> !pins_o.cs_n)
    else $error("strobe low while deselected");
  chk_wr_release: assert property ($rose(pins_o.wr_n) |->
    !pins_o.cs_n ##1 !pins_o.cs_n)
    else $error("deselect not after write release");
  chk_wr_width: assert property ($fell(pins_o.wr_n) |=>
    wr_low_s ##[1:30] $rose(pins_o.wr_n))
    else $error("write strobe width wrong");
  chk_cs_gap: assert property ($rose(pins_o.cs_n) |-> cs_gap_s)
    else $error("chip select gap too short");
  chk_wr_stable: assert property (!pins_o.wr_n && !$past(pins_o.wr_n)
    |-> $stable(pins_o.dc) && $stable(bus_o.data) && bus_o.oe)
    else $error("write data or select moved under strobe");
  chk_bus_dir: assert property (!pins_o.rd_n |-> !bus_o.oe)
    else $error("bus driven during read");
  chk_init_hold: assert property ($rose(pins_o.init_n) |->
    low_cnt_ff >= RST_CNT_W'(RST_LOW_CYC))
    else $error("init line released too early");
  chk_first_off: assert property (
    $fell(pins_o.wr_n) && first_wr_ff |->
    bus_o.data == CMD_DISP_OFF && !pins_o.dc)
    else $error("first command is not display off");
  chk_last_on: assert property ($changed(i_st_ff) &&
    i_st_ff == I_DONE |-> cur_ff.data == CMD_DISP_ON && !cur_ff.dc)
    else $error("sequence did not end with display on");
endmodule : oled_host_port

//--- tb/oled_dev_model.sv
// Behavioural model of the display device on the strobed parallel port.
`timescale 1ns/1ps
module oled_dev_model (
  input wire oled_host_pkg::ctl_pins_s pins_i,
  input wire logic [7:0] bus_level_i,
  input wire logic bus_oe_i,
  input wire logic [7:0] rd_val_i,
  output logic [7:0] dev_byte_o
);
  import oled_host_pkg::*;
  logic [7:0] cmd_q[$];
  logic [7:0] disp_q[$];
  int params_left = 0;
  int bad = 0;
  wire logic rd_sel;

  function automatic int param_count(input logic [7:0] op);
    case (op)
      8'h81, 8'hA8, 8'hD3, 8'hDA, 8'hD9, 8'hDB: return 1;
      default: return 0;
    endcase
  endfunction : param_count

  // Slow answer near the access limit; outside a read the bus shows the
  // inverse value so a stale byte is never mistaken for a good one.
  assign #130 rd_sel = !pins_i.cs_n && !pins_i.rd_n;
  assign dev_byte_o = rd_sel ? rd_val_i : ~rd_val_i;

  always @(posedge pins_i.wr_n) begin
    if (!pins_i.cs_n && pins_i.init_n) begin
      if (!bus_oe_i) bad++;
      if (pins_i.dc) disp_q.push_back(bus_level_i);
      else begin
        cmd_q.push_back(bus_level_i);
        if (params_left > 0) params_left--;
        else params_left = param_count(bus_level_i);
      end
    end
  end

  always @(negedge pins_i.rd_n) begin
    if (!pins_i.cs_n && bus_oe_i) bad++;
  end

  always @(negedge pins_i.init_n) begin
    cmd_q.delete();
    disp_q.delete();
    params_left = 0;
  end
endmodule : oled_dev_model

//--- tb/test_oled_host_port.sv
// Self-checking bench for the OLED host port against the device model.
`timescale 1ns/1ps
module test_oled_host_port;
  import oled_host_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  ctl_pins_s pins_o;
  bus_drive_s bus_o;
  logic [7:0] rd_val = 8'h00;
  wire logic [7:0] dev_byte;
  wire logic [7:0] bus_level;
  int errors = 0;
  int checks_done = 0;
  int wr_run = 0;
  int wr_len = 0;
  int cs_run = 0;
  int cs_len = 0;
  logic [31:0] rv;
  logic [7:0] init_exp [19] = '{8'hAE, 8'h81, 8'hFF, 8'hA8, 8'h3F, 8'hA0,
    8'hD3, 8'h00, 8'h40, 8'hC8, 8'hDA, 8'h12, 8'hD9, 8'hF1, 8'hDB, 8'h49,
    8'hA4, 8'hA6, 8'hAF};

  always #4 core_clk_i = ~core_clk_i;
  assign bus_level = bus_o.oe ? bus_o.data : dev_byte;

  oled_host_port #(.RST_LOW_CYC(4), .RST_WAIT_CYC(4)) i_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pins_o(pins_o), .bus_o(bus_o),
    .host_bus_byte_i(bus_level));

  oled_dev_model i_dev (.pins_i(pins_o), .bus_level_i(bus_level),
    .bus_oe_i(bus_o.oe), .rd_val_i(rd_val), .dev_byte_o(dev_byte));

  // Low-phase lengths of the strobe and the select, taken at their rise.
  always @(posedge core_clk_i) begin
    if (!pins_o.wr_n) wr_run <= wr_run + 1;
    else if (wr_run != 0) begin
      wr_len <= wr_run;
      wr_run <= 0;
    end
    if (!pins_o.cs_n) cs_run <= cs_run + 1;
    else if (cs_run != 0) begin
      cs_len <= cs_run;
      cs_run <= 0;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    d = reg_rdata_o;
  endtask : reg_read

  task automatic wait_stat(input int b, input logic v);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      reg_read(REG_STAT, s);
      n++;
    end while (s[b] !== v && n < 1000);
    check({31'h0, s[b]}, {31'h0, v});
  endtask : wait_stat

  // Waits on the far side first: busy may not yet show a fresh request.
  task automatic wait_disp(input int cnt);
    for (int n = 0; n < 400 && i_dev.disp_q.size() < cnt; n++)
      @(posedge core_clk_i);
    wait_stat(STAT_BUSY_BIT, 1'b0);
  endtask : wait_disp

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wait_stat(STAT_DONE_BIT, 1'b1);
    check(32'(i_dev.cmd_q.size()), 32'd19);
    check({24'h0, i_dev.cmd_q[0]}, 32'hAE);
    for (int i = 1; i < 9; i++)
      check(32'(i_dev.cmd_q[i]), 32'(init_exp[i]));
    for (int i = 9; i < 14; i++)
      check(32'(i_dev.cmd_q[i]), 32'(init_exp[i]));
    for (int i = 14; i < 18; i++)
      check(32'(i_dev.cmd_q[i]), 32'(init_exp[i]));
    check({24'h0, i_dev.cmd_q[18]}, 32'hAF);
    check(32'({pins_o.cs_n, pins_o.init_n, bus_o.oe}), 32'h6);
    reg_write(REG_TXD, 32'h15A);
    wait_disp(1);
    check({24'h0, i_dev.disp_q[0]}, 32'h5A);
    check(32'(wr_len), 32'(STB_CYC));
    check(32'(cs_len), 32'(SETUP_CYC + STB_CYC + HOLD_CYC));
    @(posedge core_clk_i);
    reg_addr_i <= REG_TXD;
    reg_wdata_i <= 32'h1A1;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wdata_i <= 32'h1A2;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    wait_disp(2);
    check(32'(i_dev.disp_q.size()), 32'd2);
    check({24'h0, i_dev.disp_q[1]}, 32'hA1);
    reg_read(REG_STAT, rv);
    check(rv, 32'hA);
    reg_write(REG_CTRL, 32'h2);
    reg_read(REG_STAT, rv);
    check(rv, 32'h2);
    rd_val <= 8'hC3;
    reg_write(REG_TXD, 32'h200);
    wait_stat(STAT_RXV_BIT, 1'b1);
    reg_read(REG_RXD, rv);
    check(rv, 32'hC3);
    // Valid rises before the hold and gap phases end, so busy lags it.
    wait_stat(STAT_BUSY_BIT, 1'b0);
    reg_read(REG_STAT, rv);
    check(rv, 32'h2);
    reg_read(4'h2, rv);
    check(rv, 32'h0);
    reg_write(4'h6, 32'hFF);
    reg_write(REG_CTRL, 32'h1);
    reg_write(REG_TXD, 32'h177);
    for (int n = 0; n < 2000 && i_dev.cmd_q.size() < 19; n++)
      @(posedge core_clk_i);
    wait_stat(STAT_DONE_BIT, 1'b1);
    check(32'(i_dev.cmd_q.size()), 32'd19);
    check(32'(i_dev.disp_q.size()), 32'd0);
    reg_read(REG_STAT, rv);
    check(rv, 32'hA);
    check(32'(i_dev.params_left), 32'd0);
    check(32'(i_dev.bad), 32'd0);
    tally_and_finish();
  end
endmodule : test_oled_host_port
